// >>> scfb_params.svh
// constants of the current feedback readback block
// assumes a 32-bit register word framed by the serial register port
// Notes on behaviour
// [RULE1] dither on: bits 15:8 hold last-cycle minimum
// [RULE2] dither off: minimum since the previous read
// [RULE3] minimum field reads zero on idle channel
// [RULE4] read reloads minimum with all ones
// [RULE5] bits 7:0 count switching periods per dither
// [RULE6] count reads zero when idle or undithered
// [RULE7] read clears the switching period count
// [RULE8] bits 23:16 hold maximum, cleared by read
// [RULE9] register is read-only; bit 31 reads zero
// [RULE10] bits 25:24 select channel one or two
// [RULE11] read side effects hit addressed channel, after latch
`ifndef SCFB_PARAMS_SVH
`define SCFB_PARAMS_SVH

// command word layout
`define SCFB_RW_BIT 31
`define SCFB_ADDR_HI 30
`define SCFB_ADDR_LO 27
`define SCFB_ADDR_FEEDBACK 4'h8
`define SCFB_CHAN_HI 25
`define SCFB_CHAN_LO 24
`define SCFB_SEL_ONE 2'h1
`define SCFB_SEL_TWO 2'h2

// answer field positions
`define SCFB_MAX_HI 23
`define SCFB_MAX_LO 16
`define SCFB_MIN_HI 15
`define SCFB_MIN_LO 8
`define SCFB_CNT_HI 7
`define SCFB_CNT_LO 0

// values after reset and after a read
`define SCFB_MIN_RELOAD 8'hFF
`define SCFB_MAX_CLEAR 8'h00
`define SCFB_CNT_CLEAR 8'h00

`endif

// >>> scfb_pkg.sv
// types of the current feedback readback block
// assumes scfb_params.svh supplies the numeric constants
`default_nettype none
package scfb_pkg;
	typedef logic [7:0] scfb_cur_t;
	typedef logic [31:0] scfb_word_t;
endpackage
`default_nettype wire

// >>> scfb_chan_if.sv
// per-channel link between the readback decoder and one tracker
// assumes both ends run on the same clock
`default_nettype none
interface scfb_chan_if;
	logic rd_clr;
	logic [7:0] min_q;
	logic [7:0] max_q;
	logic [7:0] cnt_q;
	modport tracker (input rd_clr, output min_q, output max_q, output cnt_q);
	modport ctrl (output rd_clr, input min_q, input max_q, input cnt_q);
endinterface
`default_nettype wire

// >>> scfb_tracker.sv
// min, max and switching-period capture for one channel
// assumes current samples are synchronous 8-bit codes, 1500/127 mA per count
`include "scfb_params.svh"
`default_nettype none
module scfb_tracker
	import scfb_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// channel status
	input wire logic active,
	input wire logic dither_en,
	input wire logic sample_valid,
	input wire logic [7:0] sample_cur,
	input wire logic period_end,
	input wire logic dither_end,
	// decoder side
	scfb_chan_if.tracker bus
);
	scfb_cur_t min_acc_r, max_acc_r, cnt_acc_r;
	scfb_cur_t min_r, max_r, cnt_r;
	scfb_cur_t smin, smax, scnt;

	// running values including this cycle's sample
	always_comb begin
		smin = (sample_valid && sample_cur < min_acc_r) ? sample_cur : min_acc_r;
		smax = (sample_valid && sample_cur > max_acc_r) ? sample_cur : max_acc_r;
		scnt = (period_end && cnt_acc_r != 8'hFF) ? cnt_acc_r + 8'h01 : cnt_acc_r;
	end

	// accumulators over the running dither cycle
	always_ff @(posedge clk) begin
		if (rst || (ce && (!active || !dither_en || dither_end))) begin
			min_acc_r <= `SCFB_MIN_RELOAD;
			max_acc_r <= `SCFB_MAX_CLEAR;
			cnt_acc_r <= `SCFB_CNT_CLEAR;
		end else if (ce) begin
			min_acc_r <= smin;
			max_acc_r <= smax;
			cnt_acc_r <= scnt;
		end
	end

	// minimum capture; a new sample wins over a same-cycle read
	always_ff @(posedge clk) begin
		if (rst) begin
			min_r <= `SCFB_MIN_RELOAD;
		end else if (ce) begin
			if (dither_en && dither_end) begin
				min_r <= smin; // RULE1
			end else if (dither_en) begin
				if (bus.rd_clr)
					min_r <= `SCFB_MIN_RELOAD; // RULE4
			end else if (bus.rd_clr) begin
				min_r <= sample_valid ? sample_cur : `SCFB_MIN_RELOAD; // RULE4
			end else if (sample_valid && sample_cur < min_r) begin
				min_r <= sample_cur; // RULE2
			end
		end
	end

	// maximum capture
	always_ff @(posedge clk) begin
		if (rst) begin
			max_r <= `SCFB_MAX_CLEAR;
		end else if (ce) begin
			if (dither_en && dither_end) begin
				max_r <= smax; // RULE8
			end else if (dither_en) begin
				if (bus.rd_clr)
					max_r <= `SCFB_MAX_CLEAR; // RULE8
			end else if (bus.rd_clr) begin
				max_r <= sample_valid ? sample_cur : `SCFB_MAX_CLEAR;
			end else if (sample_valid && sample_cur > max_r) begin
				max_r <= sample_cur; // RULE8
			end
		end
	end

	// switching periods per dither cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= `SCFB_CNT_CLEAR;
		end else if (ce) begin
			if (!dither_en)
				cnt_r <= `SCFB_CNT_CLEAR; // RULE6
			else if (dither_end)
				cnt_r <= scnt; // RULE5
			else if (bus.rd_clr)
				cnt_r <= `SCFB_CNT_CLEAR; // RULE7
		end
	end

	// idle channel shows zero in every field
	assign bus.min_q = active ? min_r : 8'h00; // RULE3
	assign bus.max_q = active ? max_r : 8'h00;
	assign bus.cnt_q = (active && dither_en) ? cnt_r : 8'h00; // RULE6

	a_min_reload: assert property (@(posedge clk) disable iff (rst) // RULE4
		ce && bus.rd_clr && dither_en && !dither_end |=> min_r == `SCFB_MIN_RELOAD)
		else $error("minimum not reloaded after read");
	a_cnt_clear: assert property (@(posedge clk) disable iff (rst) // RULE7
		ce && bus.rd_clr && !dither_end |=> cnt_r == `SCFB_CNT_CLEAR)
		else $error("period count not cleared after read");
	a_nodither_min: assert property (@(posedge clk) disable iff (rst) // RULE2
		ce && !dither_en && !bus.rd_clr && sample_valid |=> min_r <= $past(sample_cur))
		else $error("undithered minimum missed a sample");
	a_cycle_capture: assert property (@(posedge clk) disable iff (rst) // RULE1
		ce && dither_en && dither_end |=> min_r == $past(smin) && cnt_r == $past(scnt))
		else $error("dither cycle capture wrong");
	a_max_clear: assert property (@(posedge clk) disable iff (rst) // RULE8
		ce && bus.rd_clr && dither_en && !dither_end |=> max_r == `SCFB_MAX_CLEAR)
		else $error("maximum not cleared after read");
	c_cycle_end: cover property (@(posedge clk) ce && dither_en && dither_end && scnt != 8'h00);
endmodule
`default_nettype wire

// >>> scfb_readback.sv
// feedback register readback for two solenoid channels
// assumes the serial port delivers whole 32-bit command words, one-cycle strobe
`include "scfb_params.svh"
`default_nettype none
module scfb_readback
	import scfb_pkg::*;
#(
	parameter int NCH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// mode selects
	input wire logic cal_mode,
	input wire logic feedback_view_select,
	// per-channel status, index 0 is channel_one
	input wire logic [NCH-1:0] active,
	input wire logic [NCH-1:0] dither_en,
	input wire logic [NCH-1:0] sample_valid,
	input wire logic [NCH-1:0][7:0] sample_cur,
	input wire logic [NCH-1:0] period_end,
	input wire logic [NCH-1:0] dither_end,
	// register port
	input wire logic cmd_valid,
	input wire logic [31:0] cmd_word,
	output logic rsp_valid,
	output logic [31:0] rsp_word
);
	logic hit, view_ok;
	logic [1:0] chan_sel;
	logic [NCH-1:0] sel_vec;
	logic [NCH-1:0][7:0] min_v, max_v, cnt_v;
	scfb_word_t data_nxt;
	logic rsp_valid_r;
	scfb_word_t rsp_word_r;

	// command decode; a write bit is accepted but stores nothing
	assign hit = cmd_valid && (cmd_word[`SCFB_ADDR_HI:`SCFB_ADDR_LO] == `SCFB_ADDR_FEEDBACK);
	assign chan_sel = cmd_word[`SCFB_CHAN_HI:`SCFB_CHAN_LO];
	assign view_ok = !cal_mode && feedback_view_select;

	// one-hot channel pick from the selector code
	always_comb begin
		sel_vec = '0;
		if (chan_sel == `SCFB_SEL_ONE)
			sel_vec[0] = 1'b1; // RULE10
		else if (chan_sel == `SCFB_SEL_TWO)
			sel_vec[1] = 1'b1; // RULE10
	end

	// one tracker per channel
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		scfb_chan_if cif ();
		scfb_tracker u_trk (
			.clk(clk),
			.rst(rst),
			.ce(ce),
			.active(active[i]),
			.dither_en(dither_en[i]),
			.sample_valid(sample_valid[i]),
			.sample_cur(sample_cur[i]),
			.period_end(period_end[i]),
			.dither_end(dither_end[i]),
			.bus(cif.tracker)
		);
		// side effects only for the addressed channel
		assign cif.rd_clr = ce && hit && view_ok && sel_vec[i]; // RULE11
		assign min_v[i] = cif.min_q;
		assign max_v[i] = cif.max_q;
		assign cnt_v[i] = cif.cnt_q;
	end

	// answer word assembly
	always_comb begin
		data_nxt = '0;
		data_nxt[`SCFB_CHAN_HI:`SCFB_CHAN_LO] = chan_sel; // RULE10
		data_nxt[`SCFB_ADDR_HI:`SCFB_ADDR_LO] = `SCFB_ADDR_FEEDBACK;
		data_nxt[`SCFB_RW_BIT] = 1'b0; // RULE9
		for (int k = 0; k < NCH; k++) begin
			if (sel_vec[k] && view_ok) begin
				data_nxt[`SCFB_MAX_HI:`SCFB_MAX_LO] = max_v[k]; // RULE8
				data_nxt[`SCFB_MIN_HI:`SCFB_MIN_LO] = min_v[k]; // RULE1
				data_nxt[`SCFB_CNT_HI:`SCFB_CNT_LO] = cnt_v[k]; // RULE5
			end
		end
	end

	// answer strobe, one cycle after the command
	always_ff @(posedge clk) begin
		if (rst)
			rsp_valid_r <= 1'b0;
		else if (ce)
			rsp_valid_r <= hit;
	end

	// answer data latched before the read side effects land
	always_ff @(posedge clk) begin
		if (rst)
			rsp_word_r <= '0;
		else if (ce && hit)
			rsp_word_r <= data_nxt; // RULE11
	end

	assign rsp_valid = rsp_valid_r;
	assign rsp_word = rsp_word_r;

	a_rsp_timing: assert property (@(posedge clk) disable iff (rst) // RULE9
		ce && hit |=> rsp_valid && !rsp_word[`SCFB_RW_BIT])
		else $error("answer missing or read/write flag set");
	a_chan_echo: assert property (@(posedge clk) disable iff (rst) // RULE10
		ce && hit |=> rsp_word[`SCFB_CHAN_HI:`SCFB_CHAN_LO] == $past(chan_sel))
		else $error("channel field not echoed");
	a_idle_min_zero: assert property (@(posedge clk) disable iff (rst) // RULE3
		ce && hit && view_ok && chan_sel == `SCFB_SEL_ONE && !active[0]
		|=> rsp_word[`SCFB_MIN_HI:`SCFB_MIN_LO] == 8'h00)
		else $error("idle channel minimum not zero");
	a_nodither_cnt: assert property (@(posedge clk) disable iff (rst) // RULE6
		ce && hit && chan_sel == `SCFB_SEL_TWO && !dither_en[1]
		|=> rsp_word[`SCFB_CNT_HI:`SCFB_CNT_LO] == 8'h00)
		else $error("undithered count not zero");
	a_pre_clear_data: assert property (@(posedge clk) disable iff (rst) // RULE11
		ce && hit && view_ok && chan_sel == `SCFB_SEL_ONE
		|=> rsp_word[`SCFB_MIN_HI:`SCFB_MIN_LO] == $past(min_v[0]))
		else $error("answer did not carry the pre-read minimum");
	a_other_untouched: assert property (@(posedge clk) disable iff (rst) // RULE11
		ce && hit && chan_sel == `SCFB_SEL_ONE |-> !g_ch[1].cif.rd_clr)
		else $error("read side effect hit the wrong channel");
	c_read_one: cover property (@(posedge clk) ce && hit && view_ok && sel_vec[0]);
	c_read_two: cover property (@(posedge clk) ce && hit && view_ok && sel_vec[1]);
	c_back_to_back: cover property (@(posedge clk) ce && hit ##1 ce && hit);
endmodule
`default_nettype wire

// >>> scfb_host_model.sv
// host model: serial-port master issuing feedback register commands
// assumes the block takes a one-cycle strobe and answers one cycle later
`default_nettype none
module scfb_host_model (
	// clock
	input wire logic clk,
	// register port
	output logic cmd_valid,
	output logic [31:0] cmd_word,
	input wire logic rsp_valid,
	input wire logic [31:0] rsp_word
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle port at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_word = 32'h00000000;
	end
	// one command strobe, then a bounded wait for the answer
	task automatic xfer(input logic wr, input logic [1:0] sel, output logic [31:0] rd,
		output logic ok);
		ok = 1'b0;
		rd = 32'h00000000;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_word <= {wr, 4'h8, 1'b0, sel, 24'hA5C35A};
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_word <= ~cmd_word; // released word is never a stale command
		for (int i = 0; i < 4 && !ok; i++) begin
			#1;
			if (rsp_valid === 1'b1) begin
				ok = 1'b1;
				rd = rsp_word;
			end else
				@(posedge clk);
		end
	endtask
	// one strobe that should be ignored; reports any answer in the next three cycles
	task automatic probe(input logic [3:0] addr, output logic seen);
		seen = 1'b0;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_word <= {1'b0, addr, 1'b0, 2'h1, 24'h000000};
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_word <= ~cmd_word;
		for (int i = 0; i < 3; i++) begin
			#1;
			if (rsp_valid !== 1'b0)
				seen = 1'b1;
			@(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// >>> solenoid_current_feedback_readback_bench.sv
// self-checking bench for the two-channel feedback readback
// assumes scfb_host_model drives the register port
`include "scfb_params.svh"
`default_nettype none
module solenoid_current_feedback_readback_bench import scfb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic cal_mode = 1'b0;
	logic feedback_view_select = 1'b1;
	logic [1:0] active = 2'h3;
	logic [1:0] dither_en = 2'h0;
	logic [1:0] sample_valid = 2'h0;
	logic [1:0][7:0] sample_cur = 16'h0000;
	logic [1:0] period_end = 2'h0;
	logic [1:0] dither_end = 2'h0;
	logic cmd_valid;
	logic [31:0] cmd_word;
	logic rsp_valid;
	logic [31:0] rsp_word;
	int failures = 0;
	int checks_done = 0;
	// free-running clock
	initial forever #5 clk = ~clk;
	scfb_readback DUT (.clk(clk), .rst(rst), .ce(ce), .cal_mode(cal_mode),
		.feedback_view_select(feedback_view_select), .active(active),
		.dither_en(dither_en), .sample_valid(sample_valid), .sample_cur(sample_cur),
		.period_end(period_end), .dither_end(dither_end), .cmd_valid(cmd_valid),
		.cmd_word(cmd_word), .rsp_valid(rsp_valid), .rsp_word(rsp_word));
	scfb_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
		.rsp_valid(rsp_valid), .rsp_word(rsp_word));
	// verdict and end of run
	task automatic tally_and_finish();
		if (failures == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// compare one answer word
	task automatic chk(input string what, input scfb_word_t exp, input scfb_word_t got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// compare one single-bit result
	task automatic chk_flag(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask
	// expected answer: flag clear, address echo, selector echo, fields
	function automatic scfb_word_t fb(input logic [1:0] sel, input scfb_cur_t mx,
		input scfb_cur_t mn, input scfb_cur_t cnt);
		return {1'b0, `SCFB_ADDR_FEEDBACK, 1'b0, sel, mx, mn, cnt};
	endfunction
	// read through the host and judge the answer
	task automatic rd(input logic wr, input logic [1:0] sel, input scfb_word_t exp,
		input string what);
		scfb_word_t w;
		logic ok;
		host.xfer(wr, sel, w, ok);
		if (ok !== 1'b1) begin
			failures++;
			tally_and_finish();
		end else
			chk(what, exp, w);
	endtask
	// one status pulse: 0 sample, 1 period end, 2 dither end
	task automatic pulse(input int ch, input int kind, input scfb_cur_t cur);
		@(posedge clk);
		sample_valid[ch] <= (kind == 0);
		period_end[ch] <= (kind == 1);
		dither_end[ch] <= (kind == 2);
		sample_cur[ch] <= cur;
		@(posedge clk);
		sample_valid[ch] <= 1'b0;
		period_end[ch] <= 1'b0;
		dither_end[ch] <= 1'b0;
		sample_cur[ch] <= ~cur;
	endtask
	// fresh channels after reset
	task automatic t_reset();
		rd(0, 2'h1, fb(2'h1, 8'h00, 8'hFF, 8'h00), "reset one");
		rd(0, 2'h2, fb(2'h2, 8'h00, 8'hFF, 8'h00), "reset two");
	endtask
	// channel one undithered, written-to attempt, periods ignored
	task automatic t_undithered();
		pulse(0, 0, 8'h30);
		pulse(0, 1, 8'h00);
		pulse(0, 0, 8'h10);
		pulse(0, 0, 8'h50);
		rd(1, 2'h1, fb(2'h1, 8'h50, 8'h10, 8'h00), "undith");
		pulse(0, 0, 8'h44);
		pulse(0, 0, 8'h12);
	endtask
	// channel two dithered, then read side effects kept per channel
	task automatic t_dithered();
		@(posedge clk);
		dither_en <= 2'h2;
		pulse(1, 0, 8'h40);
		pulse(1, 1, 8'h00);
		pulse(1, 0, 8'h22);
		pulse(1, 1, 8'h00);
		pulse(1, 0, 8'h61);
		pulse(1, 1, 8'h00);
		pulse(1, 2, 8'h00);
		rd(0, 2'h2, fb(2'h2, 8'h61, 8'h22, 8'h03), "dith");
		rd(0, 2'h2, fb(2'h2, 8'h00, 8'hFF, 8'h00), "dith reread");
		rd(0, 2'h1, fb(2'h1, 8'h44, 8'h12, 8'h00), "other chan");
		rd(0, 2'h1, fb(2'h1, 8'h00, 8'hFF, 8'h00), "one reread");
	endtask
	// idle channels and unused selectors read zero
	task automatic t_idle();
		@(posedge clk);
		active <= 2'h0;
		rd(0, 2'h1, fb(2'h1, 8'h00, 8'h00, 8'h00), "idle one");
		rd(0, 2'h2, fb(2'h2, 8'h00, 8'h00, 8'h00), "idle two");
		@(posedge clk);
		active <= 2'h3;
		rd(0, 2'h0, fb(2'h0, 8'h00, 8'h00, 8'h00), "sel 00");
		rd(0, 2'h3, fb(2'h3, 8'h00, 8'h00, 8'h00), "sel 11");
	endtask
	// other views answer zero without side effects; frozen enable; foreign address
	task automatic t_refused();
		logic seen;
		pulse(0, 0, 8'h27);
		@(posedge clk);
		cal_mode <= 1'b1;
		rd(0, 2'h1, fb(2'h1, 8'h00, 8'h00, 8'h00), "cal view");
		@(posedge clk);
		cal_mode <= 1'b0;
		feedback_view_select <= 1'b0;
		rd(0, 2'h1, fb(2'h1, 8'h00, 8'h00, 8'h00), "other view");
		@(posedge clk);
		feedback_view_select <= 1'b1;
		ce <= 1'b0;
		pulse(0, 0, 8'h05);
		host.probe(4'h8, seen);
		chk_flag("frozen strobe", 1'b0, seen);
		@(posedge clk);
		ce <= 1'b1;
		host.probe(4'h3, seen);
		chk_flag("foreign addr", 1'b0, seen);
		rd(0, 2'h1, fb(2'h1, 8'h27, 8'h27, 8'h00), "kept view");
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_undithered();
		t_dithered();
		t_idle();
		t_refused();
		tally_and_finish();
	end
endmodule
`default_nettype wire
